/* hdl/qstop_pkg.sv */
// Package of constants and types for the quick stop option decoder
package qstop_pkg;

    localparam int OPT_W = 16;
    localparam int MODE_W = 4;
    localparam int RATE_W = 32;

    // Option codes
    localparam logic [OPT_W-1:0] OPT_DBRAKE = 16'h0000;
    localparam logic [OPT_W-1:0] OPT_MODE_OFF = 16'h0001;
    localparam logic [OPT_W-1:0] OPT_QSD_OFF = 16'h0002;
    localparam logic [OPT_W-1:0] OPT_MODE_HOLD = 16'h0005;
    localparam logic [OPT_W-1:0] OPT_QSD_HOLD = 16'h0006;
    localparam logic [OPT_W-1:0] OPT_RESET = 16'h0002;

    // Control mode codes
    localparam logic [MODE_W-1:0] CSP_MODE = 4'h0;
    localparam logic [MODE_W-1:0] CSV_MODE = 4'h1;
    localparam logic [MODE_W-1:0] CST_MODE = 4'h2;
    localparam logic [MODE_W-1:0] PROFILE_POSITION_MODE = 4'h3;
    localparam logic [MODE_W-1:0] PROFILE_VELOCITY_MODE = 4'h4;
    localparam logic [MODE_W-1:0] PROFILE_TORQUE_MODE = 4'h5;
    localparam logic [MODE_W-1:0] CONTINUOUS_TORQUE_MODE = 4'h6;
    localparam logic [MODE_W-1:0] JOG_MODE = 4'h7;
    localparam logic [MODE_W-1:0] HOMING_MODE = 4'h8;
    localparam logic [MODE_W-1:0] POINT_TABLE_MODE = 4'h9;

    // Deceleration source select
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_QUICK_STOP,
        SRC_PROFILE,
        SRC_HOMING,
        SRC_POINT_TABLE,
        SRC_DBRAKE
    } dec_src_t;

    // Register offsets of the plain register port
    localparam logic [3:0] ADDR_OPTION = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_QSD = 4'h2;
    localparam logic [3:0] ADDR_PROFILE = 4'h3;
    localparam logic [3:0] ADDR_HOMING = 4'h4;
    localparam logic [3:0] ADDR_REFUSED = 4'h5;

endpackage

/* hdl/qstop_option_map.sv */
// Combinational map from option code and control mode to stop action
`timescale 1ns/10ps
module qstop_option_map
(
    input wire logic [qstop_pkg::OPT_W-1:0] option,
    input wire logic [qstop_pkg::MODE_W-1:0] mode,
    output qstop_pkg::dec_src_t src,
    output logic hold_on,
    output logic supported
);

    logic torque;
    logic cyclic_pv;
    logic prof;

    always_comb
    begin
        torque = (mode == qstop_pkg::CST_MODE) || (mode == qstop_pkg::PROFILE_TORQUE_MODE)
            || (mode == qstop_pkg::CONTINUOUS_TORQUE_MODE);
        cyclic_pv = (mode == qstop_pkg::CSP_MODE) || (mode == qstop_pkg::CSV_MODE);
        prof = (mode == qstop_pkg::PROFILE_POSITION_MODE)
            || (mode == qstop_pkg::PROFILE_VELOCITY_MODE) || (mode == qstop_pkg::JOG_MODE);
        src = qstop_pkg::SRC_DBRAKE;
        hold_on = 1'b0;
        supported = 1'b1;
        case (option)
            qstop_pkg::OPT_DBRAKE:
            begin
                src = qstop_pkg::SRC_DBRAKE;
            end
            qstop_pkg::OPT_MODE_OFF, qstop_pkg::OPT_MODE_HOLD:
            begin
                hold_on = (option == qstop_pkg::OPT_MODE_HOLD);
                if (torque)
                begin
                    src = qstop_pkg::SRC_DBRAKE;
                    hold_on = 1'b0;
                end
                else if (cyclic_pv)
                    src = qstop_pkg::SRC_QUICK_STOP;
                else if (prof)
                    src = qstop_pkg::SRC_PROFILE;
                else if (mode == qstop_pkg::HOMING_MODE)
                    src = qstop_pkg::SRC_HOMING;
                else
                    src = qstop_pkg::SRC_POINT_TABLE;
            end
            qstop_pkg::OPT_QSD_OFF, qstop_pkg::OPT_QSD_HOLD:
            begin
                src = torque ? qstop_pkg::SRC_DBRAKE : qstop_pkg::SRC_QUICK_STOP;
                hold_on = !torque && (option == qstop_pkg::OPT_QSD_HOLD);
            end
            default:
            begin
                supported = 1'b0;
                src = qstop_pkg::SRC_NONE;
            end
        endcase
    end

endmodule // qstop_option_map

/* hdl/quick_stop_option_decoder.sv */
// Quick stop option decoder: register port, stop sequencer, rate select
`timescale 1ns/10ps
// Overview of operation
// - Code 0: immediate servo-off, dynamic brake
// - Code 1: mode deceleration, then servo-off
// - Code 2: quick stop deceleration, then servo-off
// - Code 5 cyclic pos/vel: quick stop rate, hold
// - Code 1/2/5/6 torque modes: immediate dynamic brake
// - Code 5 profile/jog: profile deceleration, hold
// - Code 5 homing: homing acceleration rate, hold
// - Code 5 point table: entry time constant, hold
// - Code 6 motion modes: quick stop rate, hold
module quick_stop_option_decoder
#(
    parameter int RATE_W = qstop_pkg::RATE_W
)
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic [qstop_pkg::MODE_W-1:0] MODE,
    input wire logic [RATE_W-1:0] POINT_TABLE_DECEL,
    input wire logic QUICK_STOP,
    input wire logic STANDSTILL,
    output logic [RATE_W-1:0] DECEL_RATE,
    output logic DECEL_ACTIVE,
    output logic DBRAKE,
    output logic SERVO_ON,
    output logic SWITCH_ON_DISABLED,
    output logic QUICK_STOP_ACTIVE
);

    typedef enum logic [2:0] {
        ST_RUN,
        ST_DECEL,
        ST_HOLD,
        ST_DISABLED
    } stop_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [qstop_pkg::OPT_W-1:0] option_r, option_nxt;
    logic [RATE_W-1:0] qsd_r, qsd_nxt;
    logic [RATE_W-1:0] prof_r, prof_nxt;
    logic [RATE_W-1:0] home_r, home_nxt;
    logic refused_r, refused_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    stop_state_t state_r, state_nxt;
    logic hold_r, hold_nxt;
    qstop_pkg::dec_src_t src_r, src_nxt;
    logic [RATE_W-1:0] rate_r, rate_nxt;

    qstop_pkg::dec_src_t map_src;
    logic map_hold;
    logic map_ok;
    logic [qstop_pkg::OPT_W-1:0] wr_opt;
    logic wr_ok;

    qstop_option_map u_map
    (
        .option(option_r),
        .mode(MODE),
        .src(map_src),
        .hold_on(map_hold),
        .supported(map_ok)
    );

    qstop_option_map u_check
    (
        .option(wr_opt),
        .mode(MODE),
        .src(),
        .hold_on(),
        .supported(wr_ok)
    );

    always_comb
    begin
        wr_opt = WDATA[qstop_pkg::OPT_W-1:0];
        option_nxt = option_r;
        qsd_nxt = qsd_r;
        prof_nxt = prof_r;
        home_nxt = home_r;
        refused_nxt = refused_r;
        rdata_nxt = 32'h00000000;
        if (WR)
        begin
            case (ADDR)
                qstop_pkg::ADDR_OPTION:
                begin
                    // Refused codes leave the previous option in force
                    if (wr_ok)
                        option_nxt = wr_opt;
                    refused_nxt = !wr_ok;
                end
                qstop_pkg::ADDR_QSD: qsd_nxt = WDATA[RATE_W-1:0];
                qstop_pkg::ADDR_PROFILE: prof_nxt = WDATA[RATE_W-1:0];
                qstop_pkg::ADDR_HOMING: home_nxt = WDATA[RATE_W-1:0];
                default: ;
            endcase
        end
        if (RD)
        begin
            case (ADDR)
                qstop_pkg::ADDR_OPTION: rdata_nxt = 32'(option_r);
                qstop_pkg::ADDR_STATUS:
                    rdata_nxt = {24'h000000, 1'b0, 3'(state_r), 1'b0, 3'(src_r)};
                qstop_pkg::ADDR_QSD: rdata_nxt = 32'(qsd_r);
                qstop_pkg::ADDR_PROFILE: rdata_nxt = 32'(prof_r);
                qstop_pkg::ADDR_HOMING: rdata_nxt = 32'(home_r);
                qstop_pkg::ADDR_REFUSED: rdata_nxt = {31'h00000000, refused_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stop sequencer
    always_comb
    begin
        state_nxt = state_r;
        hold_nxt = hold_r;
        src_nxt = src_r;
        rate_nxt = rate_r;
        case (state_r)
            ST_RUN:
            begin
                // Source, hold and rate are latched at the request; later writes do not disturb a stop
                if (QUICK_STOP && map_ok)
                begin
                    src_nxt = map_src;
                    hold_nxt = map_hold;
                    case (map_src)
                        qstop_pkg::SRC_QUICK_STOP: rate_nxt = qsd_r;
                        qstop_pkg::SRC_PROFILE: rate_nxt = prof_r;
                        qstop_pkg::SRC_HOMING: rate_nxt = home_r;
                        qstop_pkg::SRC_POINT_TABLE: rate_nxt = POINT_TABLE_DECEL;
                        default: rate_nxt = '0;
                    endcase
                    if (map_src == qstop_pkg::SRC_DBRAKE)
                        state_nxt = ST_DISABLED;
                    else
                        state_nxt = ST_DECEL;
                end
            end
            ST_DECEL:
            begin
                // State changes only once the motor is at rest
                if (STANDSTILL)
                    state_nxt = hold_r ? ST_HOLD : ST_DISABLED;
            end
            ST_HOLD:
            begin
                // Release relies on controller position follow-up in csp
                if (!QUICK_STOP)
                    state_nxt = ST_RUN;
            end
            ST_DISABLED:
            begin
                if (!QUICK_STOP)
                begin
                    state_nxt = ST_RUN;
                    src_nxt = qstop_pkg::SRC_NONE;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            option_r <= qstop_pkg::OPT_RESET;
            qsd_r <= '0;
            prof_r <= '0;
            home_r <= '0;
            refused_r <= 1'b0;
            rdata_r <= 32'h00000000;
            state_r <= ST_RUN;
            hold_r <= 1'b0;
            src_r <= qstop_pkg::SRC_NONE;
            rate_r <= '0;
        end
        else
        begin
            option_r <= option_nxt;
            qsd_r <= qsd_nxt;
            prof_r <= prof_nxt;
            home_r <= home_nxt;
            refused_r <= refused_nxt;
            rdata_r <= rdata_nxt;
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            src_r <= src_nxt;
            rate_r <= rate_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign RDATA = rdata_r;
    assign DECEL_RATE = rate_r;
    assign DECEL_ACTIVE = (state_r == ST_DECEL);
    assign DBRAKE = (state_r == ST_DISABLED) && (src_r == qstop_pkg::SRC_DBRAKE);
    assign SWITCH_ON_DISABLED = (state_r == ST_DISABLED);
    assign QUICK_STOP_ACTIVE = (state_r == ST_DECEL) || (state_r == ST_HOLD);
    assign SERVO_ON = (state_r != ST_DISABLED);

endmodule // quick_stop_option_decoder

/* tb/qstop_controller_model.sv */
// Motion controller and motor model at the far side of the stop link
`timescale 1ns/10ps
module qstop_controller_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic [3:0] len,
    input wire logic decel_active,
    output logic quick_stop,
    output logic standstill
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic qs_r;
    logic qs_nxt;
    ////////////////////////////////////////////////////////////////////////////////
    // Release held back while braking: position follow-up needs a stopped motor
    always_comb
    begin
        cnt_nxt = decel_active ? cnt_r + 4'h1 : 4'h0;
        qs_nxt = decel_active ? qs_r : req;
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r <= 4'h0;
            qs_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            qs_r <= qs_nxt;
        end
    end
    // Motor only reports rest at the end of a deceleration
    assign standstill = decel_active && (cnt_r >= len);
    assign quick_stop = qs_r;
endmodule // qstop_controller_model

/* tb/qstop_checker_properties.sv */
// Checker of quick stop state outputs
`timescale 1ns/10ps
module qstop_checker
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic QUICK_STOP,
    input wire logic STANDSTILL,
    input wire logic DECEL_ACTIVE,
    input wire logic DBRAKE,
    input wire logic SERVO_ON,
    input wire logic SWITCH_ON_DISABLED,
    input wire logic QUICK_STOP_ACTIVE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////////////
    property p_take; QUICK_STOP && !QUICK_STOP_ACTIVE && !SWITCH_ON_DISABLED
        |=> QUICK_STOP_ACTIVE || SWITCH_ON_DISABLED; endproperty
    property p_brake; DBRAKE |-> SWITCH_ON_DISABLED && !SERVO_ON; endproperty
    property p_off; SWITCH_ON_DISABLED |-> !SERVO_ON && !QUICK_STOP_ACTIVE; endproperty
    property p_decel; DECEL_ACTIVE |-> QUICK_STOP_ACTIVE && SERVO_ON && !DBRAKE; endproperty
    property p_no_abort; DECEL_ACTIVE && !STANDSTILL |=> DECEL_ACTIVE; endproperty
    property p_stop; DECEL_ACTIVE && STANDSTILL
        |=> !DECEL_ACTIVE && (QUICK_STOP_ACTIVE != SWITCH_ON_DISABLED); endproperty
    property p_hold; QUICK_STOP_ACTIVE && !DECEL_ACTIVE && QUICK_STOP
        |=> QUICK_STOP_ACTIVE && SERVO_ON && !DECEL_ACTIVE; endproperty
    property p_dis_stay; SWITCH_ON_DISABLED && QUICK_STOP |=> SWITCH_ON_DISABLED; endproperty
    property p_release; (SWITCH_ON_DISABLED || QUICK_STOP_ACTIVE && !DECEL_ACTIVE) && !QUICK_STOP
        |=> !QUICK_STOP_ACTIVE && !SWITCH_ON_DISABLED && SERVO_ON; endproperty
    a_take: assert property (p_take) else $error("stop request not taken");
    a_brake: assert property (p_brake) else $error("brake without servo-off");
    a_off: assert property (p_off) else $error("disabled state with servo on");
    a_decel: assert property (p_decel) else $error("bad outputs in deceleration");
    a_no_abort: assert property (p_no_abort) else $error("deceleration cut short");
    a_stop: assert property (p_stop) else $error("no end state after rest");
    a_hold: assert property (p_hold) else $error("hold state lost");
    a_dis_stay: assert property (p_dis_stay) else $error("disabled state lost");
    a_release: assert property (p_release) else $error("stop not released");
    c_brake: cover property ($rose(DBRAKE));
    c_hold: cover property ($fell(DECEL_ACTIVE) && QUICK_STOP_ACTIVE);
    c_off: cover property ($fell(DECEL_ACTIVE) && SWITCH_ON_DISABLED);
endmodule // qstop_checker
bind quick_stop_option_decoder qstop_checker chk_u (.CLK(CLK), .RSTN(RSTN),
    .QUICK_STOP(QUICK_STOP), .STANDSTILL(STANDSTILL), .DECEL_ACTIVE(DECEL_ACTIVE),
    .DBRAKE(DBRAKE), .SERVO_ON(SERVO_ON), .SWITCH_ON_DISABLED(SWITCH_ON_DISABLED),
    .QUICK_STOP_ACTIVE(QUICK_STOP_ACTIVE));

/* tb/quick_stop_option_decoder_tb.sv */
// Self-checking testbench of the quick stop option decoder
`timescale 1ns/10ps
module quick_stop_option_decoder_tb;
    logic CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0, req = 1'b0;
    logic [3:0] ADDR = 4'h0, MODE = 4'h0, len = 4'h1;
    logic [31:0] WDATA = 32'h0, RDATA, DECEL_RATE, PT = 32'h0000_4444;
    logic QUICK_STOP, STANDSTILL, DECEL_ACTIVE, DBRAKE, SERVO_ON, SWITCH_ON_DISABLED, QSA;
    logic [31:0] rate [0:4] = '{32'h0, 32'h0000_1111, 32'h0000_2222, 32'h0000_3333, 32'h0000_4444};
    logic [15:0] opts [0:4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
    int num_errors = 0, checks = 0;
    always #4 CLK = ~CLK;
    quick_stop_option_decoder dut_u (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .MODE(MODE), .POINT_TABLE_DECEL(PT),
        .QUICK_STOP(QUICK_STOP), .STANDSTILL(STANDSTILL), .DECEL_RATE(DECEL_RATE),
        .DECEL_ACTIVE(DECEL_ACTIVE), .DBRAKE(DBRAKE), .SERVO_ON(SERVO_ON),
        .SWITCH_ON_DISABLED(SWITCH_ON_DISABLED), .QUICK_STOP_ACTIVE(QSA));
    qstop_controller_model ctl_u (.clk(CLK), .rstn(RSTN), .req(req), .len(len),
        .decel_active(DECEL_ACTIVE), .quick_stop(QUICK_STOP), .standstill(STANDSTILL));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(RDATA, e);
    endtask
    // Expected deceleration source, worked out per option and mode
    function automatic logic [2:0] src_of(input logic [15:0] o, input logic [3:0] m);
        if (o == 16'h0 || m == 4'h2 || m == 4'h5 || m == 4'h6) return 3'h5;
        if (o == 16'h2 || o == 16'h6 || m < 4'h2) return 3'h1;
        if (m == 4'h8) return 3'h3;
        if (m == 4'h3 || m == 4'h4 || m == 4'h7) return 3'h2;
        return 3'h4;
    endfunction
    task automatic run(input logic [15:0] o, input logic [3:0] m);
        logic [2:0] s;
        logic h;
        int n;
        s = src_of(o, m);
        h = (o >= 16'h5) && (s != 3'h5);
        wr(4'h0, {16'h0, o});
        MODE <= m; len <= m[0] ? 4'h1 : 4'h6; req <= 1'b1;
        n = 0;
        while (!QSA && !SWITCH_ON_DISABLED && n < 10)
        begin
            @(posedge CLK); #1 n++;
        end
        chk(QSA || SWITCH_ON_DISABLED, 1'b1);
        chk(DBRAKE, s == 3'h5);
        chk(DECEL_RATE, (s == 3'h5) ? 32'h0 : rate[s]);
        n = 0;
        while (DECEL_ACTIVE && n < 20)
        begin
            @(posedge CLK); #1 n++;
        end
        chk(DECEL_ACTIVE, 1'b0);
        chk(SERVO_ON, h);
        rd(4'h1, {25'h0, h ? 3'h2 : 3'h3, 1'b0, s});
        @(posedge CLK);
        req <= 1'b0;
        repeat (3) @(posedge CLK);
        #1 chk({QSA, SWITCH_ON_DISABLED, SERVO_ON}, 3'h1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        rd(4'h0, 32'h2);
        for (int i = 2; i < 5; i++) wr(i[3:0], rate[i - 1]);
        for (int i = 2; i < 5; i++) rd(i[3:0], rate[i - 1]);
        foreach (opts[k]) for (int m = 0; m < 10; m++) run(opts[k], m[3:0]);
        foreach (opts[k])
        begin
            wr(4'h0, {28'h0, k[3:0] + 4'h3 + (k > 1 ? 4'h2 : 4'h0)});
            rd(4'h5, 32'h1);
            rd(4'h0, 32'h6);
        end
        wr(4'h0, 32'h1);
        rd(4'h5, 32'h0);
        rd(4'hF, 32'h0);
        report_and_stop;
    end
    // Around 5 us of traffic; allow ample margin
    initial
    begin
        #400000;
        num_errors++;
        report_and_stop;
    end
endmodule // quick_stop_option_decoder_tb
